//--- design/watchdog_reset_sequencer.sv
// Watchdog reset sequencer: carries out soft and hard resets after a watchdog
// event, keeps the event tally and raises the fail-safe transition.
// Assumes an external regulator sequencer that ramps, powers down and reports
// back on the same clock; pins arrive asynchronously and are synchronised here.
`timescale 1ns/10ps

// Functional notes
// [RL1] Internal expiry hard; pin event per type bit
// [RL2] Every event runs exactly one soft/hard reset; at the limit the code takes fail-safe instead
// [RL3] Host reset stays released during soft reset
// [RL4] Soft reset reloads only the fixed subset
// [RL5] Keep bit preserves regulator configuration
// [RL6] Only sequenced, unkept regulators return default
// [RL7] Bucks ramp by scaling; linears step at once
// [RL8] Unkept, unsequenced regulators switch off immediately
// [RL9] Wait at least 30 us before run
// [RL10] Interrupt at soft completion unless masked
// [RL11] Hard reset reloads every register
// [RL12] Hard reset powers down in sequence order
// [RL13] Sequenced power-good output disabled in order
// [RL14] Wait 30 us, reload, await fail-hold release
// [RL15] Standby pin selects standby after reset
// [RL16] Each event increments four-bit tally
// [RL17] Tally at limit takes fail-safe transition
// [RL18] Host clears tally while healthy
// [RL19] Limit loaded from default at power-up
// [RL20] Off states clear the tally
// [RL21] Reset sequences never overlap
module watchdog_reset_sequencer
  import wd_reset_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYCLES
) (
  input wire logic clock, // 125 MHz clock
  input wire logic rst_b, // Async reset, active low
  input wire logic clk_en, // Freezes all state while low
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic [DATA_W-1:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
  // Event sources
  input wire logic wd_pin_n, // External watchdog pin, async
  input wire logic wd_expire, // Internal timer expiry pulse
  input wire logic standby_pin, // Standby request pin, async
  input wire logic fail_hold_n, // Fail-hold pin, async
  input wire logic off_state, // Device is in an off state
  input wire logic power_up, // Power-up pulse
  input wire logic [TALLY_W-1:0] event_limit_default, // Default event limit
  // Regulator sequencer feedback
  input wire logic [BUCK_COUNT-1:0] buck_in_seq, // Buck is in power-up sequence
  input wire logic [LINEAR_COUNT-1:0] linear_in_seq, // Linear is in power-up sequence
  input wire logic [BUCK_COUNT-1:0] buck_at_default, // Buck ramp reached default
  input wire logic pdn_done, // Power-down and its delay finished
  input wire logic pdn_reset_slot, // Host reset slot reached in power-down
  input wire logic pdn_pg_slot, // Power-good slot reached in power-down
  input wire logic pg_is_gpo, // Power-good pin used as output
  input wire logic pg_in_seq, // Power-good pin in power-up sequence
  // Commands out
  output reg_cmd_t reg_cmd, // Per-regulator pulses
  output seq_cmd_t seq_cmd, // Sequence pulses
  output logic voltage_ramp_scaling, // Bucks ramp with scaling while high
  output logic host_reset_out_n, // Host processor reset, active low
  output logic power_good_pin_off, // Power-good output disabled
  output logic irq_out_n // Interrupt, active low
);

  if (SETTLE_CYC < 1 || SETTLE_CYC > 4095) begin : g_bad_settle
    $error("SETTLE_CYC out of range");
  end

  typedef enum logic [2:0] {ST_RUN, ST_SOFT_RAMP, ST_SOFT_WAIT, ST_HARD_PDN, ST_HARD_WAIT,
    ST_HARD_HOLD, ST_FAILSAFE} state_t;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic wd_pin_prev_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_q <= 3'h7;
      pin_sync_q <= 3'h7;
      wd_pin_prev_q <= 1'b1;
    end else if (clk_en) begin
      pin_meta_q <= {fail_hold_n, standby_pin, wd_pin_n};
      pin_sync_q <= pin_meta_q;
      wd_pin_prev_q <= pin_sync_q[0];
    end
  end

  wire pin_event = wd_pin_prev_q & ~pin_sync_q[0];
  wire standby_req = pin_sync_q[1];
  wire fail_hold_released = pin_sync_q[2];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  state_t state_q, state_d;
  logic pin_type_q;
  logic [TALLY_W-1:0] tally_q, tally_d;
  logic [TALLY_W-1:0] limit_q;
  logic [BUCK_COUNT-1:0] buck_keep_q;
  logic [LINEAR_COUNT-1:0] linear_keep_q;
  logic irq_flag_q, irq_mask_q;
  logic [11:0] wait_q;
  logic host_reset_n_q, pg_off_q, irq_n_q, ramp_q;
  logic [BUCK_COUNT-1:0] buck_pending_q;
  reg_cmd_t reg_cmd_q, reg_cmd_d;
  seq_cmd_t seq_cmd_q, seq_cmd_d;
  logic [DATA_W-1:0] rdata_q;

  // Register decode
  wire wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
  wire wr_tally = reg_wr & (reg_addr == REG_TALLY);
  wire wr_bkeep = reg_wr & (reg_addr == REG_BUCK_KEEP);
  wire wr_lkeep = reg_wr & (reg_addr == REG_LINEAR_KEEP);
  wire wr_irq = reg_wr & (reg_addr == REG_IRQ);

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  wire idle = (state_q == ST_RUN);
  // Events during a running sequence are dropped, not queued
  wire event_go = idle & ~off_state & (wd_expire | pin_event); // RL21
  // Internal expiry always forces hard
  wire event_hard = wd_expire | (pin_type_q == RESET_HARD); // RL1
  wire [TALLY_W-1:0] tally_inc = (tally_q == 4'hF) ? tally_q : tally_q + 4'h1;
  wire at_limit = (tally_inc == limit_q); // RL17
  wire settle_done = (wait_q == 12'h000);

  // ---------------------------------------------------------------
  // Per-regulator soft reset commands
  // ---------------------------------------------------------------
  logic [BUCK_COUNT-1:0] buck_restore_w, buck_off_w;
  logic [LINEAR_COUNT-1:0] linear_restore_w, linear_off_w;

  genvar gi;
  generate
    for (gi = 0; gi < BUCK_COUNT; gi++) begin : g_buck
      assign buck_restore_w[gi] = ~buck_keep_q[gi] & buck_in_seq[gi]; // RL5 RL6
      assign buck_off_w[gi] = ~buck_keep_q[gi] & ~buck_in_seq[gi]; // RL8
    end
    for (gi = 0; gi < LINEAR_COUNT; gi++) begin : g_linear
      assign linear_restore_w[gi] = ~linear_keep_q[gi] & linear_in_seq[gi]; // RL5 RL6
      assign linear_off_w[gi] = ~linear_keep_q[gi] & ~linear_in_seq[gi]; // RL8
    end
  endgenerate

  // Only restored bucks need to finish their ramp; linears step at once
  wire ramps_done = &(buck_at_default | ~buck_pending_q); // RL7

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    reg_cmd_d = '0;
    seq_cmd_d = '0;
    case (state_q)
      ST_RUN: begin
        if (event_go) begin
          if (at_limit) begin
            state_d = ST_FAILSAFE; // RL17
            seq_cmd_d.failsafe = 1'b1;
          end else if (event_hard) begin
            state_d = ST_HARD_PDN; // RL2
            seq_cmd_d.pdn_start = 1'b1; // RL12
          end else begin
            state_d = ST_SOFT_RAMP; // RL2
            seq_cmd_d.soft_reload = 1'b1; // RL4
            reg_cmd_d.buck_restore = buck_restore_w; // RL7
            reg_cmd_d.buck_off = buck_off_w; // RL8
            reg_cmd_d.linear_restore = linear_restore_w; // RL7
            reg_cmd_d.linear_off = linear_off_w; // RL8
          end
        end
      end
      ST_SOFT_RAMP: begin
        if (ramps_done) begin
          state_d = ST_SOFT_WAIT;
        end
      end
      ST_SOFT_WAIT: begin
        if (settle_done) begin
          state_d = ST_RUN; // RL9
          seq_cmd_d.enter_run = ~standby_req; // RL15
          seq_cmd_d.enter_standby = standby_req; // RL15
        end
      end
      ST_HARD_PDN: begin
        if (pdn_done) begin
          state_d = ST_HARD_WAIT;
        end
      end
      ST_HARD_WAIT: begin
        if (settle_done) begin
          state_d = ST_HARD_HOLD;
          seq_cmd_d.full_reload = 1'b1; // RL11 RL14
        end
      end
      ST_HARD_HOLD: begin
        if (fail_hold_released) begin
          state_d = ST_RUN; // RL14
          seq_cmd_d.powerup_ready = 1'b1;
          seq_cmd_d.enter_run = ~standby_req; // RL15
          seq_cmd_d.enter_standby = standby_req; // RL15
        end
      end
      ST_FAILSAFE: begin
        // Left only through the off-state override below
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    if (off_state) begin
      state_d = ST_RUN;
    end
  end

  // Tally: off state beats an event, and an event beats a host write
  assign tally_d = off_state ? TALLY_RST : // RL20
                   event_go ? tally_inc : // RL16
                   wr_tally ? reg_wdata[TALLY_LSB +: TALLY_W] : // RL18
                   tally_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_RUN;
      tally_q <= TALLY_RST;
      reg_cmd_q <= '0;
      seq_cmd_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      tally_q <= tally_d;
      reg_cmd_q <= reg_cmd_d;
      seq_cmd_q <= seq_cmd_d;
    end
  end

  // Settle counter, loaded on entry to either wait state
  wire wait_load = ((state_q == ST_SOFT_RAMP) & ramps_done) |
                   ((state_q == ST_HARD_PDN) & pdn_done);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 12'h000;
    end else if (clk_en) begin
      if (wait_load) begin
        wait_q <= 12'(SETTLE_CYC - 1); // RL9 RL14
      end else if (!settle_done) begin
        wait_q <= wait_q - 12'h001;
      end
    end
  end

  // Bucks still ramping in this soft reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      buck_pending_q <= '0;
      ramp_q <= 1'b0;
    end else if (clk_en) begin
      if (state_d == ST_SOFT_RAMP && idle) begin
        buck_pending_q <= buck_restore_w;
      end
      ramp_q <= (state_d == ST_SOFT_RAMP); // RL7
    end
  end

  // ---------------------------------------------------------------
  // Host reset and power-good output
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      host_reset_n_q <= 1'b1;
      pg_off_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == ST_HARD_PDN && pdn_reset_slot) begin
        host_reset_n_q <= 1'b0; // RL12
      end else if (state_q != ST_HARD_PDN && state_q != ST_HARD_WAIT &&
                   state_q != ST_HARD_HOLD) begin
        host_reset_n_q <= 1'b1; // RL3
      end
      if (state_q == ST_HARD_PDN && pdn_pg_slot && pg_is_gpo && pg_in_seq) begin
        pg_off_q <= 1'b1; // RL13
      end else if (idle) begin
        pg_off_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  wire soft_end = (state_q == ST_SOFT_WAIT) & settle_done;
  wire irq_clear = wr_irq & reg_wdata[IRQ_FLAG_BIT];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_type_q <= PIN_TYPE_RST;
      limit_q <= LIMIT_RST;
      buck_keep_q <= '0;
      linear_keep_q <= '0;
      irq_flag_q <= 1'b0;
      irq_mask_q <= IRQ_MASK_RST;
      irq_n_q <= 1'b1;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        pin_type_q <= reg_wdata[CTRL_PIN_TYPE_BIT]; // RL1
      end
      if (power_up) begin
        limit_q <= event_limit_default; // RL19
      end
      if (wr_bkeep) begin
        buck_keep_q <= reg_wdata[BUCK_COUNT-1:0];
      end
      if (wr_lkeep) begin
        linear_keep_q <= reg_wdata[LINEAR_COUNT-1:0];
      end
      if (wr_irq) begin
        irq_mask_q <= reg_wdata[IRQ_MASK_BIT];
      end
      // Set wins over a write-one clear
      if (soft_end) begin
        irq_flag_q <= 1'b1; // RL10
      end else if (irq_clear) begin
        irq_flag_q <= 1'b0;
      end
      irq_n_q <= ~(irq_flag_q & ~irq_mask_q); // RL10
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  wire [DATA_W-1:0] rd_mux =
    (reg_addr == REG_CTRL) ? {7'h00, pin_type_q} :
    (reg_addr == REG_STATUS) ? {5'h00, state_q} :
    (reg_addr == REG_TALLY) ? {limit_q, tally_q} :
    (reg_addr == REG_BUCK_KEEP) ? DATA_W'(buck_keep_q) :
    (reg_addr == REG_LINEAR_KEEP) ? DATA_W'(linear_keep_q) :
    (reg_addr == REG_IRQ) ? {6'h00, irq_mask_q, irq_flag_q} :
    8'h00;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_cmd = reg_cmd_q;
  assign seq_cmd = seq_cmd_q;
  assign voltage_ramp_scaling = ramp_q;
  assign host_reset_out_n = host_reset_n_q;
  assign power_good_pin_off = pg_off_q;
  assign irq_out_n = irq_n_q;

endmodule

//--- design/wd_reset_pkg.sv
// Constants, register map and carrier types for the watchdog reset sequencer.
// Assumes a single 125 MHz clock domain and an 8-bit register port.
package wd_reset_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SETTLE_TIME_NS = 30000;
  // Least time, rounded up to whole cycles
  localparam int SETTLE_CYCLES = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------
  // Regulator population
  // ---------------------------------------------------------------
  localparam int BUCK_COUNT = 5;
  localparam int LINEAR_COUNT = 3;

  // ---------------------------------------------------------------
  // Register map (8-bit data)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_TALLY = 4'h2;
  localparam logic [ADDR_W-1:0] REG_BUCK_KEEP = 4'h3;
  localparam logic [ADDR_W-1:0] REG_LINEAR_KEEP = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ = 4'h5;

  // CTRL fields
  localparam int CTRL_PIN_TYPE_BIT = 0;
  // TALLY fields
  localparam int TALLY_LSB = 0;
  localparam int LIMIT_LSB = 4;
  localparam int TALLY_W = 4;
  // IRQ fields
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_MASK_BIT = 1;

  // Reset values
  localparam logic PIN_TYPE_RST = 1'b0;
  localparam logic IRQ_MASK_RST = 1'b1;
  localparam logic [TALLY_W-1:0] TALLY_RST = 4'h0;
  localparam logic [TALLY_W-1:0] LIMIT_RST = 4'hF;

  // Pin event reset type encoding
  localparam logic RESET_SOFT = 1'b0;
  localparam logic RESET_HARD = 1'b1;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [BUCK_COUNT-1:0] buck_restore;
    logic [BUCK_COUNT-1:0] buck_off;
    logic [LINEAR_COUNT-1:0] linear_restore;
    logic [LINEAR_COUNT-1:0] linear_off;
  } reg_cmd_t;

  typedef struct packed {
    logic soft_reload;
    logic full_reload;
    logic pdn_start;
    logic powerup_ready;
    logic failsafe;
    logic enter_run;
    logic enter_standby;
  } seq_cmd_t;

endpackage

//--- tb/reg_seq_model.sv
// Regulator power sequencer model facing the reset sequencer.
// Same clock; ramps and power-down take a settable extra delay.
`timescale 1ns/10ps
module reg_seq_model
  import wd_reset_pkg::*;
(
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic [3:0] slow, // Extra delay cycles
  input wire reg_cmd_t reg_cmd, // Regulator pulses
  input wire seq_cmd_t seq_cmd, // Sequence pulses
  output logic [BUCK_COUNT-1:0] buck_at_default, // Ramp done
  output logic pdn_done, // Power-down finished
  output logic pdn_reset_slot, // Host slot reached
  output logic pdn_pg_slot // Pin slot reached
);
  logic [BUCK_COUNT-1:0] done_q;
  logic [4:0] ramp_q;
  logic [4:0] pdn_q;
  // Ready drops with the command, so no stale high is seen
  assign buck_at_default = done_q & ~reg_cmd.buck_restore;
  assign pdn_reset_slot = pdn_q >= 5'h3;
  assign pdn_pg_slot = pdn_q >= 5'h5;
  assign pdn_done = pdn_q >= 5'h8 + {1'h0, slow};
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      done_q <= '1;
      ramp_q <= '0;
      pdn_q <= '0;
    end else begin
      if (|reg_cmd.buck_restore) begin
        done_q <= ~reg_cmd.buck_restore;
        ramp_q <= 5'h2 + {1'h0, slow};
      end else if (ramp_q != 5'h0) begin
        ramp_q <= ramp_q - 5'h1;
        done_q <= (ramp_q == 5'h1) ? '1 : done_q;
      end
      if (seq_cmd.full_reload) begin
        pdn_q <= '0;
      end else if (seq_cmd.pdn_start || (pdn_q != 5'h0 && pdn_q != 5'h1F)) begin
        pdn_q <= pdn_q + 5'h1;
      end
    end
  end
endmodule

//--- tb/watchdog_reset_sequencer_test.sv
// Self-checking bench for the watchdog reset sequencer.
// Register port tasks, pin stimulus and a regulator sequencer model.
`timescale 1ns/10ps
module watchdog_reset_sequencer_test;
  import wd_reset_pkg::*;
  localparam int SC = 4;
  // Sequence pulse masks, struct order
  localparam logic [6:0] SOFT = 7'h40, FULL = 7'h20, PDN = 7'h10, PUP = 7'h08, FS = 7'h04;
  localparam logic [6:0] RUN = 7'h02;
  logic clock = 1'h0;
  logic rst_b = 1'h0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'h0, reg_rd = 1'h0, wd_pin_n = 1'h1, wd_expire = 1'h0, standby_pin = 1'h0;
  logic fail_hold_n = 1'h1, off_state = 1'h0, power_up = 1'h0;
  logic pg_is_gpo = 1'h1, pg_in_seq = 1'h1;
  logic [TALLY_W-1:0] event_limit_default = 4'h3;
  logic [BUCK_COUNT-1:0] buck_in_seq = 5'h07;
  logic [LINEAR_COUNT-1:0] linear_in_seq = 3'h3;
  logic [3:0] slow = 4'h0;
  logic [DATA_W-1:0] reg_rdata;
  logic [BUCK_COUNT-1:0] buck_at_default;
  logic pdn_done, pdn_reset_slot, pdn_pg_slot, voltage_ramp_scaling, host_reset_out_n;
  logic power_good_pin_off, irq_out_n;
  reg_cmd_t reg_cmd;
  seq_cmd_t seq_cmd;
  int fail_count = 0;
  int tests_run = 0;
  int n;
  always #4 clock = ~clock;
  watchdog_reset_sequencer #(.SETTLE_CYC(SC)) DUT (.clock, .rst_b, .clk_en(1'h1), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wd_pin_n, .wd_expire, .standby_pin,
    .fail_hold_n, .off_state, .power_up, .event_limit_default, .buck_in_seq, .linear_in_seq,
    .buck_at_default, .pdn_done, .pdn_reset_slot, .pdn_pg_slot, .pg_is_gpo,
    .pg_in_seq, .reg_cmd, .seq_cmd, .voltage_ramp_scaling, .host_reset_out_n,
    .power_good_pin_off, .irq_out_n);
  reg_seq_model PM (.clock, .rst_b, .slow, .reg_cmd, .seq_cmd, .buck_at_default, .pdn_done,
    .pdn_reset_slot, .pdn_pg_slot);
  // ----
  // Tasks
  // ----
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 check(nm, reg_rdata, exp);
  endtask
  // Bounded wait for any pulse in the mask; n counts the cycles
  task automatic wait_seq(input logic [6:0] m, input string nm);
    n = 0;
    #1;
    while ((seq_cmd & m) === 7'h0) begin
      @(posedge clock);
      #1 n++;
      if (n > 400) begin
        fail_count++;
        $display("Error %s expected pulse seen none", nm);
        complete_run();
      end
    end
  endtask
  task automatic soft_run(input logic irq_n);
    @(posedge clock);
    wd_pin_n <= 1'h0;
    wait_seq(SOFT, "soft start");
    check("reg cmd", reg_cmd, 16'h3614);
    check("host soft", host_reset_out_n, 1'h1);
    check("ramp", voltage_ramp_scaling, 1'h1);
    wait_seq(RUN, "soft end");
    // Model ramp spends three edges or more before the settle wait starts
    check("settle", n > SC + 2, 1'h1);
    @(posedge clock);
    wd_pin_n <= 1'h1;
    #1 check("irq", irq_out_n, irq_n);
    wr(REG_IRQ, 8'h03);
    @(posedge clock);
    #1 check("irq clear", irq_out_n, 1'h1);
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    #10 check("rst outs", {reg_rdata, host_reset_out_n, irq_out_n, power_good_pin_off}, 16'h6);
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    rd(REG_TALLY, 8'hF0, "limit rst");
    rd(REG_IRQ, 8'h02, "irq rst");
    rd(REG_CTRL, 8'h00, "ctrl rst");
    @(posedge clock);
    power_up <= 1'h1;
    @(posedge clock);
    power_up <= 1'h0;
    rd(REG_TALLY, 8'h30, "limit load");
    rd(4'hF, 8'h00, "unmapped");
    wr(REG_BUCK_KEEP, 8'h01);
    wr(REG_LINEAR_KEEP, 8'h01);
    wr(REG_IRQ, 8'h00);
    soft_run(1'h0);
    rd(REG_TALLY, 8'h31, "tally one");
    wr(REG_CTRL, 8'h01);
    fail_hold_n <= 1'h0;
    standby_pin <= 1'h1;
    slow <= 4'h3;
    wd_pin_n <= 1'h0;
    wait_seq(PDN, "hard start");
    wait_seq(FULL, "reload");
    check("pdn wait", n > SC + 11, 1'h1);
    check("hard outs", {host_reset_out_n, power_good_pin_off}, 16'h1);
    repeat (20) @(posedge clock);
    rd(REG_STATUS, 8'h05, "held");
    @(posedge clock);
    fail_hold_n <= 1'h1;
    wait_seq(PUP, "power up");
    check("to standby", seq_cmd, 16'h09);
    @(posedge clock);
    wd_pin_n <= 1'h1;
    standby_pin <= 1'h0;
    #1 check("host back", host_reset_out_n, 1'h1);
    rd(REG_TALLY, 8'h32, "tally two");
    wr(REG_CTRL, 8'h00);
    wr(REG_TALLY, 8'h00);
    @(posedge clock);
    wd_expire <= 1'h1;
    pg_in_seq <= 1'h0;
    @(posedge clock);
    wd_expire <= 1'h0;
    wait_seq(PDN, "expiry hard");
    @(posedge clock);
    wd_expire <= 1'h1;
    @(posedge clock);
    wd_expire <= 1'h0;
    wait_seq(RUN, "hard end");
    check("expiry outs", {host_reset_out_n, power_good_pin_off}, 16'h0);
    rd(REG_TALLY, 8'h31, "dropped event");
    soft_run(1'h1);
    @(posedge clock);
    wd_expire <= 1'h1;
    @(posedge clock);
    wd_expire <= 1'h0;
    wait_seq(FS, "fail-safe");
    rd(REG_STATUS, 8'h06, "fail state");
    rd(REG_TALLY, 8'h33, "tally three");
    @(posedge clock);
    off_state <= 1'h1;
    @(posedge clock);
    off_state <= 1'h0;
    rd(REG_TALLY, 8'h30, "tally off");
    rd(REG_STATUS, 8'h00, "off state");
    complete_run();
  end
endmodule

//--- tb/wd_reset_chk.sv
// Concurrent checks on the watchdog reset sequencer ports.
// Bound to every instance of the design below.
`timescale 1ns/10ps
module wd_reset_chk
  import wd_reset_pkg::*;
#(
  parameter int SETTLE_CYC = SETTLE_CYCLES
) (
  input wire logic clock, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic off_state, // Off state
  input wire logic fail_hold_n, // Fail-hold pin
  input wire logic [BUCK_COUNT-1:0] buck_in_seq, // Sequenced bucks
  input wire logic [LINEAR_COUNT-1:0] linear_in_seq, // Sequenced linears
  input wire logic pdn_reset_slot, // Host slot reached
  input wire logic pdn_pg_slot, // Pin slot reached
  input wire logic pg_is_gpo, // Pin is an output
  input wire logic pg_in_seq, // Pin is sequenced
  input wire reg_cmd_t reg_cmd, // Regulator pulses
  input wire seq_cmd_t seq_cmd, // Sequence pulses
  input wire logic voltage_ramp_scaling, // Ramp level
  input wire logic host_reset_out_n, // Host reset
  input wire logic power_good_pin_off // Pin disabled
);
  // ----
  // Helper state
  // ----
  logic [15:0] wait_q;
  logic soft_q;
  wire logic done_w = seq_cmd.enter_run | seq_cmd.enter_standby;
  wire logic stop_w = done_w | seq_cmd.pdn_start | seq_cmd.failsafe | off_state;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= '0;
      soft_q <= 1'h0;
    end else begin
      wait_q <= voltage_ramp_scaling ? '0 : wait_q + {15'h0, ~&wait_q};
      soft_q <= seq_cmd.soft_reload | (soft_q & ~stop_w);
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ----
  // Assertions
  // ----
  soft_host_a: assert property (soft_q |-> host_reset_out_n)
    else $error("host reset low in soft reset");
  kinds_excl_a: assert property ($onehot0({seq_cmd.soft_reload, seq_cmd.pdn_start,
    seq_cmd.failsafe}) && !(soft_q && (seq_cmd.soft_reload || seq_cmd.pdn_start)))
    else $error("overlapping reset sequences");
  ramp_soft_a: assert property (seq_cmd.soft_reload |-> voltage_ramp_scaling)
    else $error("no ramp on soft reset");
  restore_seq_a: assert property (((reg_cmd.buck_restore & ~$past(buck_in_seq)) == '0)
    && ((reg_cmd.linear_restore & ~$past(linear_in_seq)) == '0)) else $error("bad restore");
  off_unseq_a: assert property (((reg_cmd.buck_off & $past(buck_in_seq)) == '0)
    && ((reg_cmd.linear_off & $past(linear_in_seq)) == '0)) else $error("bad switch off");
  cmd_soft_a: assert property ((|reg_cmd) |-> seq_cmd.soft_reload)
    else $error("regulator pulse outside soft reset");
  run_stby_a: assert property (!(seq_cmd.enter_run && seq_cmd.enter_standby))
    else $error("run and standby together");
  hard_host_a: assert property ($fell(host_reset_out_n) |-> $past(pdn_reset_slot))
    else $error("host reset before its slot");
  pg_off_a: assert property ($rose(power_good_pin_off) |->
    $past(pdn_pg_slot && pg_is_gpo && pg_in_seq)) else $error("pin disabled out of slot");
  settle_wait_a: assert property (soft_q && done_w |-> wait_q >= SETTLE_CYC)
    else $error("soft reset ended early");
  hold_release_a: assert property (seq_cmd.powerup_ready |-> $past(fail_hold_n, 3))
    else $error("power-up while fail-hold low");
  soft_c: cover property (seq_cmd.soft_reload);
  hard_c: cover property (seq_cmd.powerup_ready);
  fail_c: cover property (seq_cmd.failsafe);
endmodule

bind watchdog_reset_sequencer wd_reset_chk #(.SETTLE_CYC(SETTLE_CYC)) chk_i (.clock, .rst_b,
  .off_state, .fail_hold_n, .buck_in_seq, .linear_in_seq, .pdn_reset_slot, .pdn_pg_slot,
  .pg_is_gpo, .pg_in_seq, .reg_cmd, .seq_cmd, .voltage_ramp_scaling, .host_reset_out_n,
  .power_good_pin_off);
